// [hw/packet_and_synth_config_regs.v]
// Purpose: packet and synthesizer configuration registers with the data path they steer
// Assumes: serial pins synchronous to clk, sclk much slower than clk
// Notes: header bit 7 = read, bit 6 = burst, bits 5:0 = address
`timescale 1ns/100ps
`include "pkt_synth_defs.vh"

module word_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rstn,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rp_q];
  always @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!rstn) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo

// How it works
// - Format 00 moves transmit data through the internal FIFO; receive bytes go out on rx_fifo_byte.
// - Format 01 is synchronous serial; transmit bits come from pin 0.
// - Format 10 transmits PN9 test data; receive behaves as FIFO mode.
// - Format 11 is asynchronous serial; data in on pin 0, received data out.
// - Legacy bit 3 selects the predecessor checksum implementation.
// - Checksum enable appends checksum on transmit and checks it on receive.
// - Length mode 00 uses the fixed length value for every packet.
// - Length mode 01 takes length from first byte after sync.
// - Length mode 10 is infinite; code 11 is reserved.
// - Received address compared with node address; 0x00 and 0xFF optional broadcast.
// - Unsigned channel times spacing is added to the base frequency.
// - In receive, IF word times 64 units is subtracted from the base.
// - Signed offset word, four units per step, is added to the base.
// - Top two bits of the base frequency word always read 01.
// - Base frequency is the 24-bit word over three registers.
// - Address filter mode selects none, exact, plus 0x00, plus 0x00 and 0xFF.
// - Length value is the maximum in variable mode, exact in fixed mode.
module packet_and_synth_config_regs (
  input wire clk,
  input wire rstn,
  input wire csn,
  input wire sclk,
  input wire mosi,
  output reg miso,
  output wire miso_oe,
  input wire [15:0] rf_slot_number_spacing,
  input wire [7:0] fixed_or_max_length_value,
  input wire [1:0] address_filter_mode,
  input wire rx_active,
  output reg [23:0] synth_word,
  output reg [15:0] mixer_word,
  output wire whitening_on,
  output wire crc_append,
  output wire crc_check,
  output wire legacy_checksum_compat,
  input wire [7:0] tx_byte,
  input wire tx_byte_valid,
  output wire tx_byte_ready,
  input wire tx_bit_strobe,
  output reg tx_bit,
  input wire gp_in_pin0,
  input wire rx_bit,
  input wire rx_bit_valid,
  output reg gp_output_pin0,
  output reg gp_output_pin0_oe,
  input wire rx_sync_found,
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  output reg [7:0] rx_fifo_byte,
  output reg rx_fifo_write,
  output reg [7:0] rx_length,
  output reg rx_length_error,
  output reg rx_addr_match,
  output reg rx_packet_done
);
  reg [6:0] pkt_ctrl_q;
  reg [7:0] node_addr_q;
  reg [7:0] rf_slot_number_q;
  reg [4:0] syn_if_q;
  reg [7:0] syn_off_q;
  reg [5:0] carrier_base_word_hi_q;
  reg [7:0] carrier_base_word_mid_q;
  reg [7:0] carrier_base_word_lo_q;
  reg sclk_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] sh_in_q;
  reg [7:0] sh_out_q;
  reg hdr_done_q;
  reg rd_q;
  reg burst_q;
  reg [5:0] addr_q;
  reg [7:0] rdata;
  wire [1:0] data_path_format = pkt_ctrl_q[`FLD_FMT_HI:`FLD_FMT_LO];
  wire [1:0] len_mode = pkt_ctrl_q[`FLD_LEN_HI:`FLD_LEN_LO];
  wire [23:0] carrier_base_word = {`CARRIER_BASE_WORD_TOP_BITS, carrier_base_word_hi_q, carrier_base_word_mid_q, carrier_base_word_lo_q};
  wire sclk_rise = sclk && !sclk_q && !csn;
  wire sclk_fall = !sclk && sclk_q && !csn;
  wire [7:0] sh_next = {sh_in_q[6:0], mosi};

  assign whitening_on = pkt_ctrl_q[`BIT_WHITE];
  assign legacy_checksum_compat = pkt_ctrl_q[`BIT_LEGACY];
  assign crc_append = pkt_ctrl_q[`BIT_CRC_EN];
  assign crc_check = pkt_ctrl_q[`BIT_CRC_EN];
  assign miso_oe = !csn;

  always @* begin
    case (addr_q)
      `OFS_PKT_CTRL: rdata = {1'b0, pkt_ctrl_q};
      `OFS_NODE_ADDR: rdata = node_addr_q;
      `OFS_RF_SLOT_NUMBER: rdata = rf_slot_number_q;
      `OFS_SYN_IF: rdata = {3'b000, syn_if_q};
      `OFS_SYN_OFF: rdata = syn_off_q;
      `OFS_CARRIER_BASE_WORD_HI: rdata = carrier_base_word[23:16];
      `OFS_CARRIER_BASE_WORD_MID: rdata = carrier_base_word_mid_q;
      `OFS_CARRIER_BASE_WORD_LO: rdata = carrier_base_word_lo_q;
      default: rdata = 8'h00;
    endcase
  end

  // Serial slave: first byte is the header, then data bytes
  always @(posedge clk) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      bit_cnt_q <= 4'h0;
      sh_in_q <= 8'h00;
      sh_out_q <= 8'h00;
      hdr_done_q <= 1'b0;
      rd_q <= 1'b0;
      burst_q <= 1'b0;
      addr_q <= 6'h00;
      miso <= 1'b0;
      pkt_ctrl_q <= `RST_PKT_CTRL;
      node_addr_q <= `RST_NODE_ADDR;
      rf_slot_number_q <= `RST_RF_SLOT_NUMBER;
      syn_if_q <= `RST_SYN_IF;
      syn_off_q <= `RST_SYN_OFF;
      carrier_base_word_hi_q <= `RST_CARRIER_BASE_WORD_HI;
      carrier_base_word_mid_q <= `RST_CARRIER_BASE_WORD_MID;
      carrier_base_word_lo_q <= `RST_CARRIER_BASE_WORD_LO;
    end else begin
      sclk_q <= sclk;
      if (csn) begin
        bit_cnt_q <= 4'h0;
        hdr_done_q <= 1'b0;
        sh_out_q <= 8'h00;
        miso <= 1'b0;
      end else begin
        if (sclk_fall) begin
          miso <= sh_out_q[7];
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
        if (sclk_rise) begin
          sh_in_q <= sh_next;
          bit_cnt_q <= (bit_cnt_q == 4'h7) ? 4'h0 : bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'h7) begin
            if (!hdr_done_q) begin
              hdr_done_q <= 1'b1;
              rd_q <= sh_next[7];
              burst_q <= sh_next[6];
              addr_q <= sh_next[5:0];
            end else begin
              if (!rd_q) begin
                case (addr_q)
                  `OFS_PKT_CTRL: pkt_ctrl_q <= sh_next[6:0];
                  `OFS_NODE_ADDR: node_addr_q <= sh_next;
                  `OFS_RF_SLOT_NUMBER: rf_slot_number_q <= sh_next;
                  `OFS_SYN_IF: syn_if_q <= sh_next[4:0];
                  `OFS_SYN_OFF: syn_off_q <= sh_next;
                  `OFS_CARRIER_BASE_WORD_HI: carrier_base_word_hi_q <= sh_next[5:0];
                  `OFS_CARRIER_BASE_WORD_MID: carrier_base_word_mid_q <= sh_next;
                  `OFS_CARRIER_BASE_WORD_LO: carrier_base_word_lo_q <= sh_next;
                  default: ;
                endcase
              end
              if (burst_q) begin
                addr_q <= addr_q + 6'h01;
              end
            end
          end
        end
        // Load read data once the header or previous byte is complete
        if (hdr_done_q && rd_q && bit_cnt_q == 4'h0 && sclk_q && !sclk) begin
          miso <= rdata[7];
          sh_out_q <= {rdata[6:0], 1'b0};
        end
      end
    end
  end

  // Synthesizer word in units of crystal over 2^16
  wire [23:0] rf_slot_number_term = rf_slot_number_q * rf_slot_number_spacing;
  wire [23:0] off_term = {{14{syn_off_q[7]}}, syn_off_q, 2'b00};
  wire [23:0] if_term = {13'h0000, syn_if_q, 6'h00};
  always @(posedge clk) begin
    if (!rstn) begin
      synth_word <= 24'h00_0000;
      mixer_word <= 16'h0000;
    end else begin
      synth_word <= carrier_base_word + rf_slot_number_term + off_term - (rx_active ? if_term : 24'h00_0000);
      mixer_word <= rx_active ? if_term[15:0] : 16'h0000;
    end
  end

  // Transmit source selection
  reg [8:0] pn9_q;
  reg [7:0] tx_sh_q;
  reg [2:0] tx_cnt_q;
  reg tx_full_q;
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_take = (data_path_format == `FMT_FIFO) && fifo_valid && (!tx_full_q || (tx_bit_strobe && tx_cnt_q == 3'h7));
  word_fifo #(
    .W(8),
    .D(`FIFO_DEPTH),
    .AW(4)
  ) tx_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(tx_byte),
    .in_valid(tx_byte_valid),
    .in_ready(tx_byte_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );
  always @(posedge clk) begin
    if (!rstn) begin
      pn9_q <= `PN9_SEED;
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      tx_full_q <= 1'b0;
      tx_bit <= 1'b0;
    end else begin
      if (tx_bit_strobe) begin
        case (data_path_format)
          `FMT_FIFO: begin
            if (tx_full_q) begin
              tx_bit <= tx_sh_q[7];
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              tx_cnt_q <= tx_cnt_q + 3'h1;
              if (tx_cnt_q == 3'h7 && !fifo_take) begin
                tx_full_q <= 1'b0;
              end
            end else begin
              tx_bit <= 1'b0;
            end
          end
          `FMT_SYNC: tx_bit <= gp_in_pin0;
          `FMT_PN9: begin
            tx_bit <= pn9_q[0];
            pn9_q <= {pn9_q[0] ^ pn9_q[5], pn9_q[8:1]};
          end
          `FMT_ASYNC: tx_bit <= gp_in_pin0;
          default: tx_bit <= 1'b0;
        endcase
      end
      if (fifo_take) begin
        tx_sh_q <= fifo_data;
        tx_full_q <= 1'b1;
        tx_cnt_q <= 3'h0;
      end
    end
  end

  // Receive path: serial out in async mode, bytes to FIFO otherwise
  function addr_ok;
    input [1:0] mode;
    input [7:0] rx_a;
    input [7:0] own;
    begin
      case (mode)
        `ADF_NONE: addr_ok = 1'b1;
        `ADF_NO_BC: addr_ok = (rx_a == own);
        `ADF_BC0: addr_ok = (rx_a == own) || (rx_a == `BC_ZERO);
        `ADF_BC_BOTH: addr_ok = (rx_a == own) || (rx_a == `BC_ZERO) || (rx_a == `BC_ONES);
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] byte_idx_q;
  reg in_pkt_q;
  wire var_mode = (len_mode == `LEN_VAR);
  wire [7:0] addr_pos = var_mode ? 8'h01 : 8'h00;
  always @(posedge clk) begin
    if (!rstn) begin
      gp_output_pin0 <= 1'b0;
      gp_output_pin0_oe <= 1'b0;
      rx_fifo_byte <= 8'h00;
      rx_fifo_write <= 1'b0;
      rx_length <= 8'h00;
      rx_length_error <= 1'b0;
      rx_addr_match <= 1'b0;
      rx_packet_done <= 1'b0;
      byte_idx_q <= 8'h00;
      in_pkt_q <= 1'b0;
    end else begin
      rx_fifo_write <= 1'b0;
      rx_packet_done <= 1'b0;
      gp_output_pin0_oe <= (data_path_format == `FMT_ASYNC);
      if (data_path_format == `FMT_ASYNC && rx_bit_valid) begin
        gp_output_pin0 <= rx_bit;
      end
      if (rx_sync_found) begin
        in_pkt_q <= 1'b1;
        byte_idx_q <= 8'h00;
        rx_length_error <= 1'b0;
        rx_addr_match <= 1'b0;
        rx_length <= fixed_or_max_length_value;
      end else if (in_pkt_q && rx_byte_valid && data_path_format != `FMT_ASYNC) begin
        rx_fifo_byte <= rx_byte;
        rx_fifo_write <= 1'b1;
        byte_idx_q <= byte_idx_q + 8'h01;
        if (var_mode && byte_idx_q == 8'h00) begin
          rx_length <= rx_byte;
          if (rx_byte > fixed_or_max_length_value) begin
            rx_length_error <= 1'b1;
            in_pkt_q <= 1'b0;
          end
        end
        if (byte_idx_q == addr_pos) begin
          rx_addr_match <= addr_ok(address_filter_mode, rx_byte, node_addr_q);
        end
        // Infinite and reserved modes never terminate on length
        if ((len_mode == `LEN_FIXED && byte_idx_q + 8'h01 == rx_length) ||
            (var_mode && byte_idx_q != 8'h00 && byte_idx_q == rx_length)) begin
          rx_packet_done <= 1'b1;
          in_pkt_q <= 1'b0;
        end
      end
    end
  end
endmodule // packet_and_synth_config_regs

// [hw/pkt_synth_defs.vh]
// Purpose: constants for the packet and synthesizer configuration registers
// Assumes: 6-bit register addresses, 8-bit registers
// Notes: offsets are the byte addresses seen in the serial header
`ifndef PKT_SYNTH_DEFS_VH
`define PKT_SYNTH_DEFS_VH
`define OFS_PKT_CTRL 6'h08
`define OFS_NODE_ADDR 6'h09
`define OFS_RF_SLOT_NUMBER 6'h0a
`define OFS_SYN_IF 6'h0b
`define OFS_SYN_OFF 6'h0c
`define OFS_CARRIER_BASE_WORD_HI 6'h0d
`define OFS_CARRIER_BASE_WORD_MID 6'h0e
`define OFS_CARRIER_BASE_WORD_LO 6'h0f
`define RST_PKT_CTRL 7'h45
`define RST_NODE_ADDR 8'h00
`define RST_RF_SLOT_NUMBER 8'h00
`define RST_SYN_IF 5'h0f
`define RST_SYN_OFF 8'h00
`define RST_CARRIER_BASE_WORD_HI 6'h1e
`define RST_CARRIER_BASE_WORD_MID 8'hc4
`define RST_CARRIER_BASE_WORD_LO 8'hec
`define CARRIER_BASE_WORD_TOP_BITS 2'b01
`define BIT_WHITE 6
`define FLD_FMT_HI 5
`define FLD_FMT_LO 4
`define BIT_LEGACY 3
`define BIT_CRC_EN 2
`define FLD_LEN_HI 1
`define FLD_LEN_LO 0
`define FMT_FIFO 2'b00
`define FMT_SYNC 2'b01
`define FMT_PN9 2'b10
`define FMT_ASYNC 2'b11
`define LEN_FIXED 2'b00
`define LEN_VAR 2'b01
`define LEN_INF 2'b10
`define ADF_NONE 2'b00
`define ADF_NO_BC 2'b01
`define ADF_BC0 2'b10
`define ADF_BC_BOTH 2'b11
`define BC_ZERO 8'h00
`define BC_ONES 8'hff
`define PN9_SEED 9'h1ff
`define IF_SHIFT 6
`define OFF_SHIFT 2
`define FIFO_DEPTH 16
`endif

// [test/packet_and_synth_config_regs_bench.sv]
`timescale 1ns/100ps
// Purpose: self-checking bench of the configuration register block
// Assumes: spi_host partner on the serial pins
// Notes: rx fifo bytes are matched through a queue
module packet_and_synth_config_regs_bench;
  logic clk, rstn, csn, sclk, mosi, miso, rx_active, tx_byte_valid, tx_byte_ready, tx_bit_strobe, tx_bit, b;
  logic gp_in_pin0, gp_output_pin0_oe, rx_sync_found, rx_byte_valid, rx_fifo_write, rx_length_error;
  logic rx_bit, rx_bit_valid, gp_output_pin0, miso_oe;
  logic rx_addr_match, rx_packet_done, whitening_on, crc_append, crc_check, legacy_checksum_compat;
  logic [1:0] address_filter_mode;
  logic [7:0] fixed_or_max_length_value, tx_byte, rx_byte, rx_fifo_byte, rx_length, r, v;
  logic [8:0] p;
  logic [15:0] rf_slot_number_spacing, mixer_word;
  logic [23:0] synth_word, e;
  logic [7:0] expq [$], pkt [$], txq [20], wv [8];
  logic [7:0] rst_v [8] = '{8'h45, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h5e, 8'hc4, 8'hec};
  logic [7:0] msk [8] = '{8'h7f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h3f, 8'hff, 8'hff};
  logic [7:0] adr [4] = '{8'h3c, 8'h00, 8'hff, 8'h55};
  int bad_count, tests_run, done_cnt, cyc, n;

  packet_and_synth_config_regs DUT (.clk(clk), .rstn(rstn), .csn(csn), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .rf_slot_number_spacing(rf_slot_number_spacing), .fixed_or_max_length_value(fixed_or_max_length_value),
    .address_filter_mode(address_filter_mode), .rx_active(rx_active), .synth_word(synth_word),
    .mixer_word(mixer_word), .whitening_on(whitening_on), .crc_append(crc_append), .crc_check(crc_check),
    .legacy_checksum_compat(legacy_checksum_compat), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_byte_ready(tx_byte_ready), .tx_bit_strobe(tx_bit_strobe), .tx_bit(tx_bit), .gp_in_pin0(gp_in_pin0),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .gp_output_pin0(gp_output_pin0),
    .gp_output_pin0_oe(gp_output_pin0_oe),
    .rx_sync_found(rx_sync_found), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .rx_fifo_byte(rx_fifo_byte), .rx_fifo_write(rx_fifo_write), .rx_length(rx_length),
    .rx_length_error(rx_length_error), .rx_addr_match(rx_addr_match), .rx_packet_done(rx_packet_done));
  spi_host host (.clk(clk), .miso(miso), .csn(csn), .sclk(sclk), .mosi(mosi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk) begin
    cyc++;
    if (rx_packet_done === 1'b1) done_cnt++;
    if (rx_fifo_write === 1'b1) check("rx byte", rx_fifo_byte, expq.size() ? expq.pop_front() : 8'hxx);
    if (cyc == 40000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer({2'b00, a, d}, r);
  endtask
  task automatic rd(input logic [5:0] a);
    host.xfer({2'b10, a, 8'h00}, r);
  endtask
  task automatic strobe;
    tx_bit_strobe = 1'b1;
    @(negedge clk) tx_bit_strobe = 1'b0;
    @(negedge clk) b = tx_bit;
  endtask
  task automatic send(input int len);
    rx_sync_found = 1'b1;
    @(negedge clk) rx_sync_found = 1'b0;
    for (int i = 0; i < len; i++) begin
      rx_byte = pkt[i];
      rx_byte_valid = 1'b1;
      expq.push_back(pkt[i]);
      @(negedge clk) rx_byte_valid = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask

  initial begin
    {rstn, rx_active, tx_byte_valid, tx_bit_strobe, gp_in_pin0, rx_sync_found, rx_byte_valid} = '0;
    {rx_bit, rx_bit_valid} = '0;
    {fixed_or_max_length_value, address_filter_mode, tx_byte, rx_byte} = '0;
    void'($urandom(32'h97dd));
    rf_slot_number_spacing = 16'($urandom);
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(6'(8 + i));
      check("reset value", r, rst_v[i]);
      wv[i] = 8'($urandom);
      if (wv[i][3] && i == 0) wv[i][6] = 1'b0;
      if (wv[i][1:0] == 2'b11 && i == 0) wv[i][0] = 1'b0;
      wr(6'(8 + i), wv[i]);
      rd(6'(8 + i));
      check("readback", r, wv[i] & msk[i] | (i == 5 ? 8'h40 : 8'h00));
    end
    wr(6'h2a, 8'h5a);
    rd(6'h2a);
    check("unmapped", r, 8'h00);
    $display("Test registers done");
    e = {2'b01, wv[5][5:0], wv[6], wv[7]} + wv[2] * rf_slot_number_spacing + {{14{wv[4][7]}}, wv[4], 2'b00};
    check("synth tx", synth_word, e);
    rx_active = 1'b1;
    repeat (2) @(negedge clk);
    check("mixer", mixer_word, {wv[3][4:0], 6'h00});
    check("synth rx", synth_word, e - {wv[3][4:0], 6'h00});
    rx_active = 1'b0;
    $display("Test synth done");
    for (int f = 0; f < 4; f++) begin
      v = {1'b0, 1'($urandom), 2'(f), 1'($urandom), 1'($urandom), 2'b01};
      if (v[3]) v[6] = 1'b0;
      // Bad-checksum flush lives outside this block and is never set
      wr(6'h08, v);
      check("flags", {whitening_on, crc_append, crc_check, legacy_checksum_compat}, {v[6], v[2], v[2], v[3]});
      check("pin oe", gp_output_pin0_oe, f == 3);
      if (f == 0) begin
        n = 0;
        // No strobes while filling: sixteen in the fifo, one already in the shift register
        while (tx_byte_ready === 1'b1 && n < 20) begin
          txq[n] = 8'($urandom);
          tx_byte = txq[n];
          tx_byte_valid = 1'b1;
          @(negedge clk) n++;
        end
        tx_byte_valid = 1'b0;
        check("fifo depth", n, 17);
        for (int k = 0; k < 137; k++) begin
          strobe();
          check("tx bit", b, k < 136 ? txq[k / 8][7 - k % 8] : 1'b0);
        end
      end else if (f == 2) begin
        p = 9'h1ff;
        for (int k = 0; k < 16; k++) begin
          strobe();
          check("pn9 bit", b, p[0]);
          p = {p[0] ^ p[5], p[8:1]};
        end
      end else begin
        for (int k = 0; k < 8; k++) begin
          gp_in_pin0 = 1'($urandom);
          rx_bit = 1'($urandom);
          rx_bit_valid = 1'b1;
          strobe();
          check("serial bit", b, gp_in_pin0);
          check("serial out", gp_output_pin0, f == 3 && rx_bit);
        end
      end
    end
    $display("Test formats done");
    wr(6'h08, 8'h45);
    wr(6'h09, 8'h3c);
    fixed_or_max_length_value = 8'h05;
    address_filter_mode = 2'b01;
    pkt = '{8'h03, 8'h3c, 8'h11, 8'h22};
    n = done_cnt;
    send(4);
    check("var packet", {rx_length, rx_length_error, rx_addr_match, 8'(done_cnt - n)}, {8'h03, 2'b01, 8'h01});
    pkt[0] = 8'h09;
    send(1);
    check("len error", rx_length_error, 1'b1);
    wr(6'h08, 8'h44);
    fixed_or_max_length_value = 8'h02;
    for (int m = 0; m < 16; m++) begin
      address_filter_mode = 2'(m / 4);
      pkt[0] = adr[m % 4];
      n = done_cnt;
      send(2);
      check("addr filter", {rx_addr_match, 8'(done_cnt - n)}, {m < 4 || m % 4 == 0 || (m > 7 && m % 4 == 1) ||
        (m > 11 && m % 4 == 2), 8'h01});
    end
    wr(6'h08, 8'h46);
    n = done_cnt;
    send(4);
    check("no done", done_cnt - n, 0);
    check("rx queue", expq.size(), 0);
    $display("Test receive done");
    summarize();
  end
endmodule // packet_and_synth_config_regs_bench

// [test/pkt_synth_chk.sv]
`timescale 1ns/100ps
// Purpose: port checks of the configuration register block
// Assumes: one clock, sync active-low reset
// Notes: synth relations hold only while the serial port is idle
module pkt_synth_chk (
  input wire clk,
  input wire rstn,
  input wire csn,
  input wire miso,
  input wire miso_oe,
  input wire rx_active,
  input wire [15:0] rf_slot_number_spacing,
  input wire [23:0] synth_word,
  input wire [15:0] mixer_word,
  input wire crc_append,
  input wire crc_check,
  input wire [7:0] rx_byte,
  input wire rx_byte_valid,
  input wire [7:0] rx_fifo_byte,
  input wire rx_fifo_write,
  input wire rx_length_error,
  input wire rx_packet_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  miso_idle_a: assert property (csn && $past(csn) |-> !miso) else $error("miso set while idle");
  miso_drive_a: assert property (miso_oe == !csn) else $error("miso enable wrong");
  rx_write_a: assert property (rx_fifo_write |-> $past(rx_byte_valid) && rx_fifo_byte == $past(rx_byte))
    else $error("rx write without byte");
  done_pulse_a: assert property (rx_packet_done |=> !rx_packet_done) else $error("done too long");
  crc_pair_a: assert property (crc_append == crc_check) else $error("crc flags differ");
  mixer_tx_a: assert property (!rx_active |=> mixer_word == 16'h0000) else $error("mixer set in tx");
  mixer_grid_a: assert property (mixer_word[5:0] == 6'h00 && mixer_word[15:11] == 5'h00)
    else $error("mixer off grid");
  if_step_a: assert property ($rose(rx_active) && csn && $stable(rf_slot_number_spacing) |=>
    synth_word == $past(synth_word) - {8'h00, mixer_word}) else $error("if not subtracted");
  synth_hold_a: assert property (csn [*3] ##0 $stable(rf_slot_number_spacing) && !rx_active && !$past(rx_active)
    |=> $stable(synth_word)) else $error("synth moved");
  done_c: cover property (rx_packet_done);
  len_err_c: cover property (rx_length_error);
  rx_on_c: cover property ($rose(rx_active));
endmodule // pkt_synth_chk

bind packet_and_synth_config_regs pkt_synth_chk chk (.clk(clk), .rstn(rstn), .csn(csn), .miso(miso), .miso_oe(miso_oe),
  .rx_active(rx_active), .rf_slot_number_spacing(rf_slot_number_spacing), .synth_word(synth_word), .mixer_word(mixer_word),
  .crc_append(crc_append), .crc_check(crc_check), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
  .rx_fifo_byte(rx_fifo_byte), .rx_fifo_write(rx_fifo_write), .rx_length_error(rx_length_error),
  .rx_packet_done(rx_packet_done));

// [test/spi_host.sv]
`timescale 1ns/100ps
// Purpose: host partner on the serial register port
// Assumes: sclk low for eight clk cycles and high for four in each bit
// Notes: one header and one data byte per select
module spi_host (
  input wire clk,
  input wire miso,
  output logic csn = 1'b1,
  output logic sclk = 1'b0,
  output logic mosi = 1'b0
);
  task automatic xfer(input logic [15:0] sh, output logic [7:0] rd);
    @(negedge clk) csn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(negedge clk);
      mosi = sh[15 - i];
      repeat (4) @(negedge clk);
      rd = {rd[6:0], miso};
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    csn = 1'b1;
    // Released line must not look like held data
    mosi = ~mosi;
  endtask
endmodule // spi_host
